// ===== common/pab_pkg.sv
// constants shared by the port a/b alternate function override logic
package pab_pkg;

  // ==========================================================
  // port geometry
  localparam int PAB_PORT_W = 8;
  localparam int PAB_PIN_COUNT = 16;
  localparam int PAB_PB_BASE = 8;

  // ==========================================================
  // port b bit positions of the alternate functions
  localparam int PAB_SCK_BIT = 7;
  localparam int PAB_MISO_BIT = 6;
  localparam int PAB_MOSI_BIT = 5;
  localparam int PAB_SS_BIT = 4;
  localparam int PAB_T0A_BIT = 3;
  localparam int PAB_T3B_BIT = 7;
  localparam int PAB_T3A_BIT = 6;
  localparam int PAB_T0B_BIT = 4;
  localparam int PAB_CAPTURE_BIT = 5;

  // ==========================================================
  // values after reset and fixed patterns
  localparam logic [7:0] PAB_RST_BYTE = 8'h00;
  localparam logic [15:0] PAB_RST_WORD = 16'h0000;
  localparam logic [7:0] PAB_ZERO_BYTE = 8'h00;
  localparam logic [7:0] PAB_ONES_BYTE = 8'hff;
  // {direction, output, pull-up disable} that turns the pull-up on
  localparam logic [2:0] PAB_PULLUP_PATTERN = 3'h2;

endpackage

// ===== src/pab_altfn.sv
// port a/b alternate function override logic, registered pin controls
//
// How it works
// - port a pull-up, direction and value overrides are held at zero.
// - port a input override enable is mask&group0 or digital-disable bit.
// - port a inputs feed change sources 7:0; pads reach converter inputs.
// - serial slave forces port b bit 7 clock pin to input.
// - serial master leaves bit 7 direction to its direction bit.
// - forced-input serial pins keep pull-up under their output bit.
// - bit 6 forced input as master, direction bit rules as slave.
// - bit 5 forced input as slave, direction bit rules as master.
// - bit 4 forced input as slave, direction bit rules as master.
// - slave interface active while select pin reads low (pad and input enable).
// - timer 3 compare b/a drive bits 7/6 only when set output.
// - timer 0 compare b/a drive bits 4/3 only when set output.
// - pwm waveform uses the same pin as the compare output.
// - port b bit 5 input also feeds timer 3 capture trigger.
// - port b pins 7:0 feed pin change sources 15:8.
// - no pull-up override: pull-up on only for pattern 0b010.
// - direction override enable hands driver to override value.
// - input override enable hands input enable to override value.
`timescale 1ns/100ps
module pab_altfn
  import pab_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_global_pullup_disable,
  input wire logic i_sleep,
  input wire logic [7:0] i_pa_dir_bits,
  input wire logic [7:0] i_pa_out_bits,
  input wire logic [7:0] i_pa_pad,
  input wire logic [7:0] i_pin_change_mask_porta,
  input wire logic i_pin_change_group0_en,
  input wire logic [7:0] i_analog_input_digital_disable,
  input wire logic [7:0] i_portb_dir_bit,
  input wire logic [7:0] i_portb_out_bit,
  input wire logic [7:0] i_pb_pad,
  input wire logic [7:0] i_pin_change_mask_pb_hi,
  input wire logic i_pin_change_group1_en,
  input wire logic i_serial_iface_enable,
  input wire logic i_serial_master_select,
  input wire logic i_spi_sck_out,
  input wire logic i_spi_slave_out,
  input wire logic i_spi_master_out,
  input wire logic i_timer3_compare_b_en,
  input wire logic i_timer3_compare_b_out,
  input wire logic i_timer3_compare_a_en,
  input wire logic i_timer3_compare_a_out,
  input wire logic i_timer0_compare_b_en,
  input wire logic i_timer0_compare_b_out,
  input wire logic i_timer0_compare_a_en,
  input wire logic i_timer0_compare_a_out,
  output logic [7:0] o_pa_drive_en,
  output logic [7:0] o_pa_drive_val,
  output logic [7:0] o_pa_pullup,
  output logic [7:0] o_pa_input_en,
  output logic [7:0] o_converter_channel_inputs,
  output logic [7:0] o_pb_drive_en,
  output logic [7:0] o_pb_drive_val,
  output logic [7:0] o_pb_pullup,
  output logic [7:0] o_pb_input_en,
  output logic [15:0] o_pin_change_src,
  output logic o_spi_sck_in,
  output logic o_spi_master_in,
  output logic o_spi_slave_in,
  output logic o_spi_select_in,
  output logic o_spi_slave_active,
  output logic o_timer3_capture_in
);

  // ==========================================================
  // registered state
  typedef struct packed {
    logic [7:0] pa_drive_en;
    logic [7:0] pa_drive_val;
    logic [7:0] pa_pullup;
    logic [7:0] pa_input_en;
    logic [7:0] adc_in;
    logic [7:0] pb_drive_en;
    logic [7:0] pb_drive_val;
    logic [7:0] pb_pullup;
    logic [7:0] pb_input_en;
    logic [15:0] pc_src;
    logic sck_in;
    logic master_in;
    logic slave_in;
    logic select_in;
    logic slave_active;
    logic capture_in;
  } pab_state_t;

  pab_state_t state_reg;
  pab_state_t state_next;

  // ==========================================================
  // override terms per pin
  logic spi_master;
  logic spi_slave;
  logic [7:0] pb_force_in;
  logic [7:0] pb_outval_override_enable;
  logic [7:0] pb_outval_override_value;
  logic [15:0] pullup_override_enable;
  logic [15:0] pullup_override_value;
  logic [15:0] direction_override_enable;
  logic [15:0] outval_override_enable;
  logic [15:0] outval_override_value;
  logic [15:0] input_en_override_enable;
  logic [15:0] input_en_override_value;
  logic [15:0] dir_all;
  logic [15:0] out_all;
  logic [15:0] pad_all;
  logic [15:0] pullup_w;
  logic [15:0] drive_en_w;
  logic [15:0] drive_val_w;
  logic [15:0] input_en_w;
  logic [15:0] din_w;

  // both roles need the interface enabled, else pins stay plain gpio
  assign spi_master = i_serial_iface_enable & i_serial_master_select;
  assign spi_slave = i_serial_iface_enable & ~i_serial_master_select;

  // which serial pins are forced to input in the current role
  always_comb
  begin
    pb_force_in = PAB_ZERO_BYTE;
    pb_force_in[PAB_SCK_BIT] = spi_slave;
    pb_force_in[PAB_MISO_BIT] = spi_master;
    pb_force_in[PAB_MOSI_BIT] = spi_slave;
    pb_force_in[PAB_SS_BIT] = spi_slave;
  end

  // port value overrides; serial outputs take priority over timers.
  // timer outputs never touch direction, so they only show when the
  // direction bit is one; pwm and compare share the same value input
  always_comb
  begin
    pb_outval_override_enable = PAB_ZERO_BYTE;
    pb_outval_override_value = PAB_ZERO_BYTE;
    pb_outval_override_enable[PAB_T3B_BIT] = spi_master | i_timer3_compare_b_en;
    pb_outval_override_value[PAB_T3B_BIT] = spi_master ? i_spi_sck_out :
                           i_timer3_compare_b_out;
    pb_outval_override_enable[PAB_T3A_BIT] = spi_slave | i_timer3_compare_a_en;
    pb_outval_override_value[PAB_T3A_BIT] = spi_slave ? i_spi_slave_out :
                           i_timer3_compare_a_out;
    pb_outval_override_enable[PAB_MOSI_BIT] = spi_master;
    pb_outval_override_value[PAB_MOSI_BIT] = i_spi_master_out;
    pb_outval_override_enable[PAB_T0B_BIT] = i_timer0_compare_b_en;
    pb_outval_override_value[PAB_T0B_BIT] = i_timer0_compare_b_out;
    pb_outval_override_enable[PAB_T0A_BIT] = i_timer0_compare_a_en;
    pb_outval_override_value[PAB_T0A_BIT] = i_timer0_compare_a_out;
  end

  // port a keeps all output-side overrides at zero
  assign pullup_override_enable = {pb_force_in, PAB_ZERO_BYTE};
  assign pullup_override_value = {i_portb_out_bit & ~{8{i_global_pullup_disable}},
                 PAB_ZERO_BYTE};
  assign direction_override_enable = {pb_force_in, PAB_ZERO_BYTE};
  assign outval_override_enable = {pb_outval_override_enable, PAB_ZERO_BYTE};
  assign outval_override_value = {pb_outval_override_value, PAB_ZERO_BYTE};
  assign input_en_override_enable = {i_pin_change_mask_pb_hi & {8{i_pin_change_group1_en}},
                  (i_pin_change_mask_porta & {8{i_pin_change_group0_en}})
                  | i_analog_input_digital_disable};
  assign input_en_override_value = {PAB_ONES_BYTE,
                  i_pin_change_mask_porta
                  & {8{i_pin_change_group0_en}}};
  assign dir_all = {i_portb_dir_bit, i_pa_dir_bits};
  assign out_all = {i_portb_out_bit, i_pa_out_bits};
  assign pad_all = {i_pb_pad, i_pa_pad};

  // ==========================================================
  // one cell per pin, port a at 7:0 and port b at 15:8
  for (genvar g = 0; g < PAB_PIN_COUNT; g++)
  begin : g_pin
    pab_pin_cell u_cell (
      .i_generic_dir_bit(dir_all[g]),
      .i_generic_out_bit(out_all[g]),
      .i_global_pullup_disable(i_global_pullup_disable),
      .i_sleep(i_sleep),
      .i_pad(pad_all[g]),
      .i_pullup_override_enable(pullup_override_enable[g]),
      .i_pullup_override_value(pullup_override_value[g]),
      .i_direction_override_enable(direction_override_enable[g]),
      .i_direction_override_value(1'b0),
      .i_outval_override_enable(outval_override_enable[g]),
      .i_outval_override_value(outval_override_value[g]),
      .i_input_en_override_enable(input_en_override_enable[g]),
      .i_input_en_override_value(input_en_override_value[g]),
      .o_pullup(pullup_w[g]),
      .o_drive_en(drive_en_w[g]),
      .o_drive_val(drive_val_w[g]),
      .o_input_en(input_en_w[g]),
      .o_alt_digital_in(din_w[g])
    );
  end

  // ==========================================================
  // next state: single output register stage, no further pipelining
  always_comb
  begin
    state_next = state_reg;
    state_next.pa_drive_en = drive_en_w[7:0];
    state_next.pa_drive_val = drive_val_w[7:0];
    state_next.pa_pullup = pullup_w[7:0];
    state_next.pa_input_en = input_en_w[7:0];
    // analog path is the raw pad, not gated by input enable
    state_next.adc_in = i_pa_pad;
    state_next.pb_drive_en = drive_en_w[15:8];
    state_next.pb_drive_val = drive_val_w[15:8];
    state_next.pb_pullup = pullup_w[15:8];
    state_next.pb_input_en = input_en_w[15:8];
    state_next.pc_src = din_w;
    state_next.sck_in = din_w[PAB_PB_BASE + PAB_SCK_BIT];
    state_next.master_in = din_w[PAB_PB_BASE + PAB_MISO_BIT];
    state_next.slave_in = din_w[PAB_PB_BASE + PAB_MOSI_BIT];
    state_next.select_in = din_w[PAB_PB_BASE + PAB_SS_BIT];
    state_next.slave_active = spi_slave
                              & ~din_w[PAB_PB_BASE + PAB_SS_BIT];
    state_next.capture_in = din_w[PAB_PB_BASE + PAB_CAPTURE_BIT];
  end

  // ==========================================================
  // state register
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // outputs straight from the state register
  assign o_pa_drive_en = state_reg.pa_drive_en;
  assign o_pa_drive_val = state_reg.pa_drive_val;
  assign o_pa_pullup = state_reg.pa_pullup;
  assign o_pa_input_en = state_reg.pa_input_en;
  assign o_converter_channel_inputs = state_reg.adc_in;
  assign o_pb_drive_en = state_reg.pb_drive_en;
  assign o_pb_drive_val = state_reg.pb_drive_val;
  assign o_pb_pullup = state_reg.pb_pullup;
  assign o_pb_input_en = state_reg.pb_input_en;
  assign o_pin_change_src = state_reg.pc_src;
  assign o_spi_sck_in = state_reg.sck_in;
  assign o_spi_master_in = state_reg.master_in;
  assign o_spi_slave_in = state_reg.slave_in;
  assign o_spi_select_in = state_reg.select_in;
  assign o_spi_slave_active = state_reg.slave_active;
  assign o_timer3_capture_in = state_reg.capture_in;

endmodule

// ===== src/pab_pin_cell.sv
// one pin's override resolution: pull-up, driver, value, input enable
`timescale 1ns/100ps
module pab_pin_cell
  import pab_pkg::*;
(
  input wire logic i_generic_dir_bit,
  input wire logic i_generic_out_bit,
  input wire logic i_global_pullup_disable,
  input wire logic i_sleep,
  input wire logic i_pad,
  input wire logic i_pullup_override_enable,
  input wire logic i_pullup_override_value,
  input wire logic i_direction_override_enable,
  input wire logic i_direction_override_value,
  input wire logic i_outval_override_enable,
  input wire logic i_outval_override_value,
  input wire logic i_input_en_override_enable,
  input wire logic i_input_en_override_value,
  output logic o_pullup,
  output logic o_drive_en,
  output logic o_drive_val,
  output logic o_input_en,
  output logic o_alt_digital_in
);

  // ==========================================================
  // override resolution, purely combinational
  always_comb
  begin
    if (i_pullup_override_enable)
      o_pullup = i_pullup_override_value;
    else
      o_pullup = ({i_generic_dir_bit, i_generic_out_bit,
                   i_global_pullup_disable} == PAB_PULLUP_PATTERN);
    // override value wins over the direction bit
    o_drive_en = i_direction_override_enable ?
                 i_direction_override_value : i_generic_dir_bit;
    o_drive_val = i_outval_override_enable ?
                  i_outval_override_value : i_generic_out_bit;
    // without override the input is cut off during sleep
    o_input_en = i_input_en_override_enable ?
                 i_input_en_override_value : ~i_sleep;
    o_alt_digital_in = i_pad & o_input_en;
  end

endmodule

// ===== verification/pab_altfn_sva.sv
// assertions on the port a/b alternate function override outputs
`timescale 1ns/100ps
module pab_altfn_sva
  import pab_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_global_pullup_disable,
  input wire logic i_sleep,
  input wire logic [7:0] i_pa_dir_bits,
  input wire logic [7:0] i_pa_pad,
  input wire logic [7:0] i_pin_change_mask_porta,
  input wire logic i_pin_change_group0_en,
  input wire logic [7:0] i_analog_input_digital_disable,
  input wire logic [7:0] i_portb_dir_bit,
  input wire logic [7:0] i_portb_out_bit,
  input wire logic [7:0] i_pb_pad,
  input wire logic [7:0] i_pin_change_mask_pb_hi,
  input wire logic i_pin_change_group1_en,
  input wire logic i_serial_iface_enable,
  input wire logic i_serial_master_select,
  input wire logic i_spi_sck_out,
  input wire logic i_timer0_compare_b_en,
  input wire logic i_timer0_compare_b_out,
  input wire logic [7:0] o_pa_drive_en,
  input wire logic [7:0] o_pa_input_en,
  input wire logic [7:0] o_pb_drive_en,
  input wire logic [7:0] o_pb_drive_val,
  input wire logic [7:0] o_pb_pullup,
  input wire logic [15:0] o_pin_change_src,
  input wire logic o_spi_slave_active,
  input wire logic o_timer3_capture_in
);
  // ==========================================================
  // expected input enables, one cycle ahead of the outputs
  logic [7:0] pa_oe;
  logic [7:0] pa_ie;
  logic [7:0] pb_ie;
  assign pa_oe = i_pin_change_mask_porta & {8{i_pin_change_group0_en}};
  assign pa_ie = pa_oe | ({8{~i_sleep}} & ~i_analog_input_digital_disable);
  assign pb_ie = (i_pin_change_mask_pb_hi & {8{i_pin_change_group1_en}})
    | {8{~i_sleep}};

  // ==========================================================
  // properties, all one cycle behind their cause.
  // the sampled reset sits in every antecedent: on the edge that releases
  // reset the outputs still hold zeros, so no attempt may start there
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_slave;
    !i_sys_rst && i_serial_iface_enable && !i_serial_master_select;
  endsequence
  sequence s_master;
    !i_sys_rst && i_serial_iface_enable && i_serial_master_select;
  endsequence
  sequence s_t0b;
    !i_sys_rst && i_timer0_compare_b_en;
  endsequence

  a_pa_dir_plain: assert property (!i_sys_rst |=>
    o_pa_drive_en == $past(i_pa_dir_bits)) else $error("pa direction");
  a_pa_input_en: assert property (!i_sys_rst |=>
    o_pa_input_en == $past(pa_ie)) else $error("pa input enable");
  a_sck_slave_in: assert property (s_slave |=>
    !o_pb_drive_en[7] && o_pb_pullup[7] ==
    $past(i_portb_out_bit[7] & ~i_global_pullup_disable))
    else $error("sck slave");
  a_master_pins: assert property (s_master |=>
    o_pb_drive_en[7] == $past(i_portb_dir_bit[7]) && !o_pb_drive_en[6]
    && o_pb_drive_val[7] == $past(i_spi_sck_out)) else $error("master");
  a_slave_inputs: assert property (s_slave |=>
    o_pb_drive_en[5:4] == 2'h0) else $error("slave inputs");
  a_slave_select: assert property (!i_sys_rst |=>
    o_spi_slave_active == $past(i_serial_iface_enable
    & ~i_serial_master_select & ~(i_pb_pad[4] & pb_ie[4])))
    else $error("slave select");
  a_timer0_value: assert property (s_t0b |=>
    o_pb_drive_val[4] == $past(i_timer0_compare_b_out))
    else $error("timer0 value");
  a_change_src: assert property (!i_sys_rst |=>
    o_pin_change_src == $past({i_pb_pad & pb_ie, i_pa_pad & pa_ie}))
    else $error("change sources");
  a_capture_in: assert property (!i_sys_rst |=>
    o_timer3_capture_in == $past(i_pb_pad[5] & pb_ie[5]))
    else $error("capture input");
endmodule

bind pab_altfn pab_altfn_sva u_sva (.*);

// ===== verification/pab_periph_model.sv
// peripheral side: serial and timer outputs from a free-running count
`timescale 1ns/100ps
module pab_periph_model
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  output logic [2:0] o_spi_out,
  output logic [3:0] o_cmp_en,
  output logic [3:0] o_cmp_val
);
  logic [7:0] cnt_reg;
  // count held at zero in reset so outputs restart predictably
  always_ff @(posedge i_core_clk)
  begin
    cnt_reg <= i_sys_rst ? 8'h00 : cnt_reg + 8'h01;
  end
  // serial output bits 0, 1, 2 change every 1, 2 and 8 cycles to catch wrong routing
  assign o_spi_out = cnt_reg[2:0] ^ {cnt_reg[3], 2'h0};
  assign o_cmp_en = cnt_reg[7:4] ^ cnt_reg[5:2];
  // pwm-like waveform: compare of count against fixed thresholds, except bit 1 which is count bit 4
  assign o_cmp_val = {cnt_reg < 8'h40, cnt_reg < 8'h80,
    cnt_reg[4], cnt_reg > 8'hc0};
endmodule

// ===== verification/tb.sv
// self-checking bench for the port a/b override block
`timescale 1ns/100ps
module tb;
  import pab_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic global_pullup_disable, sl, g0, g1, serial_iface_enable, m;
  logic [7:0] pad, pao, pap, ma, adc, pbd, pbo, pbp, mb;
  logic [2:0] so;
  logic [3:0] ce, cv;
  logic [95:0] r;
  logic [93:0] got;
  logic [93:0] q[$];
  integer seed = 99545;
  integer n_errors = 0;
  integer checked = 0;

  initial
  begin
    forever #10 i_core_clk = ~i_core_clk;
  end

  // ==========================================================
  // design and peripheral model
  pab_periph_model u_per (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .o_spi_out(so), .o_cmp_en(ce), .o_cmp_val(cv));
  pab_altfn u_dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_global_pullup_disable(global_pullup_disable), .i_sleep(sl), .i_pa_dir_bits(pad),
    .i_pa_out_bits(pao), .i_pa_pad(pap), .i_pin_change_mask_porta(ma),
    .i_pin_change_group0_en(g0), .i_analog_input_digital_disable(adc),
    .i_portb_dir_bit(pbd), .i_portb_out_bit(pbo), .i_pb_pad(pbp),
    .i_pin_change_mask_pb_hi(mb), .i_pin_change_group1_en(g1),
    .i_serial_iface_enable(serial_iface_enable), .i_serial_master_select(m),
    .i_spi_sck_out(so[2]), .i_spi_slave_out(so[1]),
    .i_spi_master_out(so[0]), .i_timer3_compare_b_en(ce[3]),
    .i_timer3_compare_b_out(cv[3]), .i_timer3_compare_a_en(ce[2]),
    .i_timer3_compare_a_out(cv[2]), .i_timer0_compare_b_en(ce[1]),
    .i_timer0_compare_b_out(cv[1]), .i_timer0_compare_a_en(ce[0]),
    .i_timer0_compare_a_out(cv[0]), .o_pa_drive_en(got[93:86]),
    .o_pa_drive_val(got[85:78]), .o_pa_pullup(got[77:70]),
    .o_pa_input_en(got[69:62]), .o_converter_channel_inputs(got[61:54]),
    .o_pb_drive_en(got[53:46]), .o_pb_drive_val(got[45:38]),
    .o_pb_pullup(got[37:30]), .o_pb_input_en(got[29:22]),
    .o_pin_change_src(got[21:6]), .o_spi_sck_in(got[5]),
    .o_spi_master_in(got[4]), .o_spi_slave_in(got[3]),
    .o_spi_select_in(got[2]), .o_spi_slave_active(got[1]),
    .o_timer3_capture_in(got[0]));

  // ==========================================================
  // reference model from the current inputs, integers avoided
  function automatic logic [93:0] model();
    logic [7:0] oe, aie, bie, fb, dv, db;
    oe = (ma & {8{g0}}) | adc;
    aie = (oe & ma & {8{g0}}) | (~oe & {8{~sl}});
    bie = (mb & {8{g1}}) | {8{~sl}};
    fb = {serial_iface_enable & ~m, serial_iface_enable & m, serial_iface_enable & ~m, serial_iface_enable & ~m, 4'h0};
    dv = pbo;
    if (serial_iface_enable & m) dv[7] = so[2]; else if (ce[3]) dv[7] = cv[3];
    if (serial_iface_enable & ~m) dv[6] = so[1]; else if (ce[2]) dv[6] = cv[2];
    if (serial_iface_enable & m) dv[5] = so[0];
    if (ce[1]) dv[4] = cv[1];
    if (ce[0]) dv[3] = cv[0];
    db = pbp & bie;
    return {pad, pao, ~pad & pao & {8{~global_pullup_disable}}, aie, pap, pbd & ~fb, dv,
      pbo & {8{~global_pullup_disable}} & (fb | ~pbd), bie, db, pap & aie, db[7:4],
      serial_iface_enable & ~m & ~db[4], db[5]};
  endfunction

  task automatic check(input string nm, input logic [93:0] s,
    input logic [93:0] e);
    checked = checked + 1;
    if (s !== e)
    begin
      n_errors = n_errors + 1;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic summarize();
    if (n_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // random inputs each rising edge; pads stand for the far master
  initial {global_pullup_disable, sl, g0, g1, serial_iface_enable, m, pad, pao, pap, ma, adc, pbd, pbo, pbp,
    mb} = 78'h0;
  always @(posedge i_core_clk)
  begin
    r = {$random(seed), $random(seed), $random(seed)};
    {global_pullup_disable, sl, g0, g1, serial_iface_enable, m, pad, pao, pap, ma, adc, pbd, pbo, pbp,
      mb} <= r[77:0];
  end

  // outputs lag inputs by one edge; reset forces all zero
  always @(negedge i_core_clk)
  begin
    if (q.size() > 0)
    begin
      check("port_a", got & {40'hff_ffff_ffff, 54'h0},
        q[0] & {40'hff_ffff_ffff, 54'h0});
      check("port_b", got & {40'h0, 32'hffff_ffff, 22'h0},
        q[0] & {40'h0, 32'hffff_ffff, 22'h0});
      check("pin_src", got & {72'h0, 16'hffff, 6'h0},
        q[0] & {72'h0, 16'hffff, 6'h0});
      check("all", got, q.pop_front());
    end
    q.push_back(i_sys_rst ? 94'h0 : model());
  end

  initial
  begin
    repeat (10) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    repeat (1500) @(posedge i_core_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    repeat (1500) @(posedge i_core_clk);
    summarize();
  end

  initial
  begin
    #80000;
    n_errors = n_errors + 1;
    summarize();
  end
endmodule
